// [hdl/rsg_pkg.sv]
`default_nettype none

package rsg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_GPIO_CFG = 4'h4;
    localparam logic [3:0] IDX_CTRL     = 4'h6;
    localparam logic [3:0] IDX_STATUS   = 4'ha;
    localparam logic [3:0] IDX_ERRLVL   = 4'hb;
    localparam logic [3:0] IDX_PIN_IN   = 4'hc;

    // GPIO config fields
    localparam int GP1_FN_LSB  = 0;
    localparam int GP2_FN_LSB  = 2;
    localparam int GP3_FN_LSB  = 4;
    localparam int GRP_IEN_BIT = 6;
    localparam int TUNE_IEN_BIT = 7;
    localparam int GP1_OUT_BIT = 8;
    localparam int GP3_OUT_BIT = 9;

    // Control fields
    localparam int RDS_EN_BIT    = 0;
    localparam int VERBOSE_BIT   = 1;
    localparam int AGC_DIS_BIT   = 2;
    localparam int PWR_EN_BIT    = 3;
    localparam int HIGH_PERF_BIT = 9;

    // Status fields
    localparam int READY_BIT   = 0;
    localparam int SYNC_BIT    = 1;
    localparam int TUNE_BIT    = 2;
    localparam int PWR_OK_BIT  = 3;
    localparam int BUS3W_BIT   = 4;

    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Pin function codes
    localparam logic [1:0] FN_HIGHZ = 2'h0;
    localparam logic [1:0] FN_SPEC  = 2'h1;
    localparam logic [1:0] FN_LOW   = 2'h2;
    localparam logic [1:0] FN_HIGH  = 2'h3;

    // Error level codes
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_FEW  = 2'h1;
    localparam logic [1:0] ERR_SOME = 2'h2;
    localparam logic [1:0] ERR_BAD  = 2'h3;
    localparam logic [2:0] ERR_FEW_MAX  = 3'h2;
    localparam logic [2:0] ERR_SOME_MAX = 3'h5;

    // Timing
    localparam int CLK_KHZ      = 20000;
    localparam int READY_MS     = 40;
    localparam int IRQ_MS       = 5;
    localparam int POWERUP_MS   = 110;
    localparam int READY_CYCLES = READY_MS * CLK_KHZ;
    localparam int IRQ_CYCLES   = IRQ_MS * CLK_KHZ;
    localparam int PWR_CYCLES   = POWERUP_MS * CLK_KHZ;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [1:0] {RSG_PWR_OFF, RSG_PWR_RAMP, RSG_PWR_ON} rsg_pwr_t;

endpackage

`default_nettype wire

// [hdl/rsg_status.sv]
// How it works
// - Decoding runs only while the RDS enable bit or the high-performance bit is set.
// - Verbose select low means standard mode, the reset default.
// - Standard mode: valid group sets ready flag for at least 40 ms.
// - Standard mode: irq enabled and pin two field 01 pulses low 5 ms.
// - Standard mode: invalid groups set no ready flag and give no pin pulse.
// - Standard mode: sync flag and error levels read zero.
// - Verbose mode: sync flag follows block synchronisation.
// - Verbose mode: received group sets ready flag only when synchronised.
// - Verbose mode: pin pulse only when synchronised and a group arrives.
// - Per block error level: 00 none, 01 1-2, 10 3-5, 11 six up.
// - High-performance option is control bit 9, off after reset.
// - High-performance: boost amplifier, force decoding, disable impulse detection.
// - Pins one and three are sampled at reset exit for bus mode.
// - Pins serve general purpose, pin two irq, pin three stereo indicator.
// - Pin functions work regardless of enable bits.
// - Gain-control disable bit turns off automatic gain control.
// - Tune irq enabled and field 01: tune done pulses pin two 5 ms.
// - Powerup completes within 110 ms of enable written to one.
`timescale 1ns/1ps
`default_nettype none

module rsg_status
    import rsg_pkg::*;
#(
    parameter int unsigned READY_CYC = rsg_pkg::READY_CYCLES,
    parameter int unsigned IRQ_CYC   = rsg_pkg::IRQ_CYCLES,
    parameter int unsigned PWR_CYC   = rsg_pkg::PWR_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        group_valid_i,
    input  wire logic        group_rcvd_i,
    input  wire logic        sync_held_i,
    input  wire logic [11:0] blk_err_cnt_i,
    input  wire logic        tune_done_i,
    input  wire logic        stereo_i,
    input  wire logic        gp_pin_one_i,
    output logic             gp_pin_one_o,
    output logic             gp_pin_one_oe_n_o,
    input  wire logic        gp_pin_two_irq_i,
    output logic             gp_pin_two_irq_o,
    output logic             gp_pin_two_irq_oe_n_o,
    input  wire logic        gp_pin_three_i,
    output logic             gp_pin_three_o,
    output logic             gp_pin_three_oe_n_o,
    output logic             rds_decode_en_o,
    output logic             lna_boost_o,
    output logic             impulse_det_dis_o,
    output logic             agc_disable_o,
    output logic             powerup_done_o,
    output logic             bus_3wire_o
);

    logic [31:0] cfg_reg;
    logic [31:0] ctrl_reg;
    logic [2:0]  pin_s1_reg;
    logic [2:0]  pin_s2_reg;
    logic [1:0]  strap_cnt_reg;
    logic        strap_done_reg;
    logic [23:0] ready_cnt_reg;
    logic [23:0] irq_cnt_reg;
    logic [23:0] pwr_cnt_reg;
    rsg_pwr_t    pwr_state_reg;
    logic        pwr_en_d_reg;
    logic        tune_flag_reg;
    logic        ready_flag_reg;
    logic        sync_reg;
    logic [7:0]  err_lvl_reg;
    logic [7:0]  err_lvl_next;
    logic        rds_run;
    logic        verbose;
    logic        group_event;
    logic        irq_fire;
    logic        access;
    logic [3:0]  index;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic [1:0]  fn1;
    logic [1:0]  fn2;
    logic [1:0]  fn3;

    assign access  = cyc_i && stb_i && !ack_o;
    assign index   = adr_i[5:2];
    assign verbose = ctrl_reg[VERBOSE_BIT];
    assign fn1     = cfg_reg[GP1_FN_LSB +: 2];
    assign fn2     = cfg_reg[GP2_FN_LSB +: 2];
    assign fn3     = cfg_reg[GP3_FN_LSB +: 2];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mask
            assign wmask[8*g +: 8] = {8{sel_i[g]}};
        end
    endgenerate

    assign rds_run = ctrl_reg[RDS_EN_BIT] || ctrl_reg[HIGH_PERF_BIT];

    assign group_event = rds_run &&
                         (verbose ? (group_rcvd_i && sync_held_i) : group_valid_i);

    assign irq_fire = (fn2 == FN_SPEC) &&
                      ((group_event && cfg_reg[GRP_IEN_BIT]) ||
                       (tune_done_i && cfg_reg[TUNE_IEN_BIT]));

    generate
        for (g = 0; g < 4; g++) begin : g_err
            logic [2:0] cnt;
            assign cnt = blk_err_cnt_i[3*g +: 3];
            assign err_lvl_next[2*g +: 2] = (cnt == 3'h0)          ? ERR_NONE :
                                            (cnt <= ERR_FEW_MAX)  ? ERR_FEW  :
                                            (cnt <= ERR_SOME_MAX) ? ERR_SOME : ERR_BAD;
        end
    endgenerate

    // Wishbone writes; unmapped addresses are acked and ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg  <= CFG_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (access && we_i && adr_i[7:6] == 2'h0) begin
            if (index == IDX_GPIO_CFG) begin
                cfg_reg <= (cfg_reg & ~wmask) | (dat_i & wmask);
            end
            if (index == IDX_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~wmask) | (dat_i & wmask);
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (adr_i[7:6] == 2'h0) begin
            case (index)
                IDX_GPIO_CFG: rdata = cfg_reg;
                IDX_CTRL:     rdata = ctrl_reg;
                IDX_STATUS: begin
                    rdata[READY_BIT]  = ready_flag_reg;
                    rdata[SYNC_BIT]   = sync_reg;
                    rdata[TUNE_BIT]   = tune_flag_reg;
                    rdata[PWR_OK_BIT] = powerup_done_o;
                    rdata[BUS3W_BIT]  = bus_3wire_o;
                end
                IDX_ERRLVL:   rdata[7:0] = err_lvl_reg;
                IDX_PIN_IN:   rdata[2:0] = pin_s2_reg;
                default:      rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            dat_o <= (access && !we_i) ? rdata : 32'h0000_0000;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end else begin
            pin_s1_reg <= {gp_pin_three_i, gp_pin_two_irq_i, gp_pin_one_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
            bus_3wire_o    <= 1'b0;
        end else if (!strap_done_reg) begin
            if (strap_cnt_reg == STRAP_WAIT) begin
                strap_done_reg <= 1'b1;
                bus_3wire_o    <= pin_s2_reg[2] && !pin_s2_reg[0];
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_cnt_reg  <= 24'h0;
            ready_flag_reg <= 1'b0;
        end else if (group_event) begin
            ready_cnt_reg  <= 24'(READY_CYC - 1);
            ready_flag_reg <= 1'b1;
        end else if (ready_cnt_reg != 24'h0) begin
            ready_cnt_reg <= ready_cnt_reg - 24'h1;
        end else begin
            ready_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg    <= 1'b0;
            err_lvl_reg <= 8'h00;
        end else if (!verbose) begin
            sync_reg    <= 1'b0;
            err_lvl_reg <= 8'h00;
        end else begin
            sync_reg <= sync_held_i && rds_run;
            if (group_event) begin
                err_lvl_reg <= err_lvl_next;
            end
        end
    end

    // Tune flag; set wins over clear while tune done is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tune_flag_reg <= 1'b0;
        end else begin
            tune_flag_reg <= tune_done_i || (tune_flag_reg && !(access && we_i &&
                             adr_i[7:6] == 2'h0 && index == IDX_STATUS &&
                             sel_i[0] && dat_i[TUNE_BIT]));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_cnt_reg <= 24'h0;
        end else if (irq_fire) begin
            irq_cnt_reg <= 24'(IRQ_CYC);
        end else if (irq_cnt_reg != 24'h0) begin
            irq_cnt_reg <= irq_cnt_reg - 24'h1;
        end
    end

    // No gating by power or enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_pin_one_o          <= 1'b0;
            gp_pin_one_oe_n_o     <= 1'b1;
            gp_pin_two_irq_o      <= 1'b0;
            gp_pin_two_irq_oe_n_o <= 1'b1;
            gp_pin_three_o        <= 1'b0;
            gp_pin_three_oe_n_o   <= 1'b1;
        end else begin
            gp_pin_one_o      <= (fn1 == FN_HIGH) ||
                                 (fn1 == FN_SPEC && cfg_reg[GP1_OUT_BIT]);
            gp_pin_one_oe_n_o <= (fn1 == FN_HIGHZ);
            gp_pin_two_irq_o      <= (fn2 == FN_HIGH) ||
                                     (fn2 == FN_SPEC && irq_cnt_reg == 24'h0);
            gp_pin_two_irq_oe_n_o <= (fn2 == FN_HIGHZ);
            gp_pin_three_o    <= (fn3 == FN_HIGH) ||
                                 (fn3 == FN_SPEC && (stereo_i || cfg_reg[GP3_OUT_BIT]));
            gp_pin_three_oe_n_o <= (fn3 == FN_HIGHZ);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_state_reg  <= RSG_PWR_OFF;
            pwr_cnt_reg    <= 24'h0;
            pwr_en_d_reg   <= 1'b0;
            powerup_done_o <= 1'b0;
        end else begin
            pwr_en_d_reg <= ctrl_reg[PWR_EN_BIT];
            case (pwr_state_reg)
                RSG_PWR_OFF: begin
                    powerup_done_o <= 1'b0;
                    if (ctrl_reg[PWR_EN_BIT] && !pwr_en_d_reg) begin
                        pwr_cnt_reg   <= 24'(PWR_CYC - 1);
                        pwr_state_reg <= RSG_PWR_RAMP;
                    end
                end
                RSG_PWR_RAMP: begin
                    if (!ctrl_reg[PWR_EN_BIT]) begin
                        pwr_state_reg <= RSG_PWR_OFF;
                    end else if (pwr_cnt_reg == 24'h0) begin
                        powerup_done_o <= 1'b1;
                        pwr_state_reg  <= RSG_PWR_ON;
                    end else begin
                        pwr_cnt_reg <= pwr_cnt_reg - 24'h1;
                    end
                end
                RSG_PWR_ON: begin
                    if (!ctrl_reg[PWR_EN_BIT]) begin
                        powerup_done_o <= 1'b0;
                        pwr_state_reg  <= RSG_PWR_OFF;
                    end
                end
                default: pwr_state_reg <= RSG_PWR_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rds_decode_en_o   <= 1'b0;
            lna_boost_o       <= 1'b0;
            impulse_det_dis_o <= 1'b0;
            agc_disable_o     <= 1'b0;
        end else begin
            rds_decode_en_o   <= rds_run;
            lna_boost_o       <= ctrl_reg[HIGH_PERF_BIT];
            impulse_det_dis_o <= ctrl_reg[HIGH_PERF_BIT];
            agc_disable_o     <= ctrl_reg[AGC_DIS_BIT];
        end
    end

    sequence s_grp_event;
        group_event;
    endsequence

    sequence s_flag_up;
        ready_flag_reg && ready_cnt_reg == 24'(READY_CYC - 1);
    endsequence

    property p_ready_set;
        @(posedge clk_i) disable iff (rst_i) s_grp_event |=> s_flag_up;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

    property p_ready_hold;
        @(posedge clk_i) disable iff (rst_i) ready_cnt_reg != 24'h0 |-> ready_flag_reg;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready flag dropped early");

    property p_invalid;
        @(posedge clk_i) disable iff (rst_i)
            (!verbose && !group_valid_i && !ready_flag_reg) |=> !ready_flag_reg;
    endproperty
    a_invalid: assert property (p_invalid) else $error("ready set without valid group");

    property p_std_zero;
        @(posedge clk_i) disable iff (rst_i)
            !verbose ##1 !verbose |-> !sync_reg && err_lvl_reg == 8'h00;
    endproperty
    a_std_zero: assert property (p_std_zero) else $error("standard mode status not zero");

    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
            verbose && rds_run |=> sync_reg == $past(sync_held_i);
    endproperty
    a_sync: assert property (p_sync) else $error("sync flag mismatch");

    property p_pulse;
        @(posedge clk_i) disable iff (rst_i)
            irq_fire |=> ##1 (!gp_pin_two_irq_o && !gp_pin_two_irq_oe_n_o) [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pin two pulse missing");

    property p_idle_high;
        @(posedge clk_i) disable iff (rst_i)
            (fn2 == FN_SPEC && irq_cnt_reg == 24'h0 && !irq_fire) ##1 fn2 == FN_SPEC
            |-> gp_pin_two_irq_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("pin two not idle high");

    property p_err_enc;
        @(posedge clk_i) disable iff (rst_i)
            verbose && group_event && blk_err_cnt_i[8:6] >= 3'h6 ##1 verbose
            |-> err_lvl_reg[5:4] == ERR_BAD;
    endproperty
    a_err_enc: assert property (p_err_enc) else $error("error level encoding wrong");

    property p_perf;
        @(posedge clk_i) disable iff (rst_i)
            ctrl_reg[HIGH_PERF_BIT] |=> rds_decode_en_o && lna_boost_o && impulse_det_dis_o;
    endproperty
    a_perf: assert property (p_perf) else $error("high performance controls off");

    property p_pwr;
        @(posedge clk_i) disable iff (rst_i)
            $rose(powerup_done_o) |-> $past(pwr_state_reg) == RSG_PWR_RAMP;
    endproperty
    a_pwr: assert property (p_pwr) else $error("powerup done out of sequence");

endmodule

`default_nettype wire

// [tb/rsg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module rsg_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    import rsg_pkg::*;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // Request held until ack is sampled; only the bench watchdog ends a wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= wr;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        // Released lines must not keep looking valid
        adr_o <= ~a;
        dat_o <= ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    function automatic logic [3:0] usable(input logic [7:0] lvl);
        for (int i = 0; i < 4; i++) begin
            usable[i] = (lvl[2*i+:2] != ERR_BAD);
        end
    endfunction
endmodule

`default_nettype wire

// [tb/rsg_status_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module rds_status_gpio_irq_bench;
    import rsg_pkg::*;

    localparam int unsigned RDY = 20;
    localparam int unsigned IRQ = 10;
    localparam int unsigned PWR = 30;
    localparam logic [7:0] A_CFG  = {2'h0, IDX_GPIO_CFG, 2'h0};
    localparam logic [7:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [7:0] A_STAT = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [7:0] A_ERR  = {2'h0, IDX_ERRLVL, 2'h0};
    localparam logic [7:0] A_PIN  = {2'h0, IDX_PIN_IN, 2'h0};
    localparam logic [31:0] PWR_ON = 32'h1 << PWR_EN_BIT;
    localparam logic [31:0] RDS_ON = PWR_ON | (32'h1 << RDS_EN_BIT);
    localparam logic [31:0] IRQ_FN = 32'(FN_SPEC) << GP2_FN_LSB;

    logic        clk_i, rst_i, cyc, stb, we, ack, gvalid, grcvd, sync_held, tune, stereo;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [11:0] err_cnt;
    logic        p1_o, p1_oe_n, p2_o, p2_oe_n, p3_o, p3_oe_n, p1_ext, p2_ext, p3_ext;
    logic        dec_en, lna, imp, agc, pwr_done, bus3;
    int          fails, cmp_count;
    wire         p1_lvl = p1_oe_n ? p1_ext : p1_o;
    wire         p2_lvl = p2_oe_n ? p2_ext : p2_o;
    wire         p3_lvl = p3_oe_n ? p3_ext : p3_o;

    rsg_status #(.READY_CYC(RDY), .IRQ_CYC(IRQ), .PWR_CYC(PWR)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .group_valid_i(gvalid),
        .group_rcvd_i(grcvd), .sync_held_i(sync_held), .blk_err_cnt_i(err_cnt),
        .tune_done_i(tune), .stereo_i(stereo), .gp_pin_one_i(p1_lvl), .gp_pin_one_o(p1_o),
        .gp_pin_one_oe_n_o(p1_oe_n), .gp_pin_two_irq_i(p2_lvl), .gp_pin_two_irq_o(p2_o),
        .gp_pin_two_irq_oe_n_o(p2_oe_n), .gp_pin_three_i(p3_lvl), .gp_pin_three_o(p3_o),
        .gp_pin_three_oe_n_o(p3_oe_n), .rds_decode_en_o(dec_en), .lna_boost_o(lna),
        .impulse_det_dis_o(imp), .agc_disable_o(agc), .powerup_done_o(pwr_done),
        .bus_3wire_o(bus3));

    rsg_host_model i_host (
        .clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic send_group(input logic v, input logic r);
        @(posedge clk_i);
        gvalid <= v;
        grcvd  <= r;
        @(posedge clk_i);
        gvalid <= 1'b0;
        grcvd  <= 1'b0;
    endtask

    // Counts low cycles of pin two over a window longer than one pulse
    task automatic expect_irq(input logic want, input string what);
        int low;
        low = 0;
        repeat (4 * IRQ) begin
            @(posedge clk_i);
            if (p2_lvl === 1'b0) low++;
        end
        check(32'(want ? low >= IRQ : low == 0), 32'h1, what);
    endtask

    task automatic t_reset();
        check({p1_oe_n, p2_oe_n, p3_oe_n, dec_en, lna}, 5'b11100, "reset pins");
        @(posedge clk_i);
        rst_i <= 1'b0;
        idle(6);
        check(bus3, 1'b1, "strap");
        i_host.rd(A_CTRL, q);
        check(q, CTRL_RESET, "ctrl reset");
        i_host.rd(A_STAT, q);
        check(q, 32'h1 << BUS3W_BIT, "status reset");
        i_host.wr(8'hc0, 32'hffff_ffff);
        i_host.rd(8'hc0, q);
        check(q, 32'h0, "unmapped read");
        i_host.rd(A_CTRL, q);
        check(q, CTRL_RESET, "unmapped write");
    endtask

    task automatic t_gpio();
        logic [3:0] e1, e3;
        e1 = 4'b1010;
        e3 = 4'b1001;
        for (int c = 0; c < 4; c++) begin
            i_host.wr(A_CFG, 32'h100 | (c << GP1_FN_LSB) | (c << GP3_FN_LSB));
            idle(2);
            check({p1_oe_n, p1_lvl, p3_lvl}, {c == 0, e1[c], e3[c]}, "pin fn");
        end
        i_host.wr(A_CFG, 32'(FN_SPEC) << GP3_FN_LSB);
        stereo <= 1'b1;
        idle(2);
        check(p3_lvl, 1'b1, "stereo pin");
        stereo <= 1'b0;
        i_host.wr(A_CFG, 32'h0);
        idle(3);
        i_host.rd(A_PIN, q);
        check(q[2:0], 3'b110, "pin inputs");
    endtask

    task automatic t_power();
        int n;
        n = 0;
        i_host.wr(A_CTRL, PWR_ON);
        while (pwr_done !== 1'b1 && n < 4 * PWR) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n <= PWR + 2), 32'h1, "powerup time");
    endtask

    task automatic t_standard();
        sync_held <= 1'b1;
        err_cnt   <= 12'hfff;
        send_group(1'b1, 1'b1);
        i_host.rd(A_STAT, q);
        check({q[READY_BIT], dec_en}, 2'b00, "rds off");
        i_host.wr(A_CTRL, RDS_ON);
        i_host.wr(A_CFG, IRQ_FN | (32'h1 << GRP_IEN_BIT));
        idle(3);
        check({p2_oe_n, p2_lvl, dec_en}, 3'b011, "irq idle");
        fork
            expect_irq(1'b0, "invalid pulse");
            send_group(1'b0, 1'b1);
        join
        i_host.rd(A_STAT, q);
        check(q[READY_BIT], 1'b0, "invalid ready");
        fork
            expect_irq(1'b1, "valid pulse");
            begin
                send_group(1'b1, 1'b0);
                i_host.rd(A_STAT, q);
                check(q[SYNC_BIT:READY_BIT], 2'b01, "valid ready");
                i_host.rd(A_ERR, q);
                check(q, 32'h0, "std levels");
                idle(6);
                i_host.rd(A_STAT, q);
                check(q[READY_BIT], 1'b1, "ready held");
                idle(RDY);
                i_host.rd(A_STAT, q);
                check(q[READY_BIT], 1'b0, "ready ends");
            end
        join
    endtask

    task automatic t_verbose();
        logic [11:0] cnt [2];
        logic [7:0]  lvl [2];
        logic [3:0]  good_blk [2];
        good_blk[0] = 4'b0111;
        good_blk[1] = 4'b1011;
        cnt[0] = {3'h7, 3'h5, 3'h2, 3'h0};
        lvl[0] = 8'he4;
        cnt[1] = {3'h0, 3'h6, 3'h3, 3'h1};
        lvl[1] = 8'h39;
        i_host.wr(A_CTRL, RDS_ON | (32'h1 << VERBOSE_BIT));
        sync_held <= 1'b0;
        fork
            expect_irq(1'b0, "unsync pulse");
            send_group(1'b0, 1'b1);
        join
        i_host.rd(A_STAT, q);
        check(q[SYNC_BIT:READY_BIT], 2'b00, "unsync ready");
        sync_held <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            err_cnt <= cnt[k];
            fork
                expect_irq(1'b1, "sync pulse");
                begin
                    send_group(1'b0, 1'b1);
                    i_host.rd(A_STAT, q);
                    check(q[SYNC_BIT:READY_BIT], 2'b11, "sync ready");
                    i_host.rd(A_ERR, q);
                    check(q, 32'(lvl[k]), "error levels");
                    check(32'(i_host.usable(q[7:0])), 32'(good_blk[k]), "usable blocks");
                end
            join
        end
        sync_held <= 1'b0;
        idle(3);
        i_host.rd(A_STAT, q);
        check(q[SYNC_BIT], 1'b0, "sync lost");
    endtask

    task automatic t_perf_tune();
        i_host.wr(A_CTRL, PWR_ON | (32'h1 << HIGH_PERF_BIT));
        idle(2);
        check({dec_en, lna, imp, agc}, 4'b1110, "high perf");
        i_host.wr(A_CTRL, PWR_ON | (32'h1 << AGC_DIS_BIT));
        idle(2);
        check({dec_en, lna, imp, agc}, 4'b0001, "gain disable");
        i_host.wr(A_CFG, IRQ_FN | (32'h1 << TUNE_IEN_BIT));
        fork
            expect_irq(1'b1, "tune pulse");
            begin
                @(posedge clk_i);
                tune <= 1'b1;
                @(posedge clk_i);
                tune <= 1'b0;
            end
        join
        i_host.rd(A_STAT, q);
        check(q[TUNE_BIT], 1'b1, "tune flag");
        i_host.wr(A_STAT, 32'h1 << TUNE_BIT);
        i_host.rd(A_STAT, q);
        check(q[TUNE_BIT], 1'b0, "tune clear");
    endtask

    initial begin
        {rst_i, gvalid, grcvd, sync_held, tune, stereo} = 6'b100000;
        err_cnt = 12'h0;
        {p1_ext, p2_ext, p3_ext} = 3'b011;
        fails = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_i);
        t_reset();
        t_gpio();
        t_power();
        t_standard();
        t_verbose();
        t_perf_tune();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("unexpected at %0t: watchdog", $time);
        conclude();
    end
endmodule

`default_nettype wire
